// file: hdl/sriu_pkg.sv
// constants and types for the scalar register instruction unit
// Notes on behaviour
// - flag branch target from T or P plus/minus shifted designator
// - flag bits 0-15 are product field, unalterable
// - late flags kept but do not change branch
// - shift byte rotates left or shifts right arithmetically
// - upper S bytes ignored, no flags set
// - decrement low 48 bits, branch if nonzero
// - branch-and-set stores next address, bits 48-63 zero
// - timer read fills T bits 0-31, clears rest
// - length transfer replaces upper 16 bits only
// - clock read fills bits 0-47, clears 48-63
// - timer load in job mode only
// - flag swap waits for outstanding flag operations
// - flag swap ends with immediate flag branch check
// - half-word index multiply, 24-bit signed product
// - full index multiply, 48-bit signed product
// - immediate enter sign-extends into low 48 bits
// - immediate increase adds into low 48 bits
// - half-word enter and increase on low 24 bits
// - float ops select result, update flags 41-46
// - truncate toward zero, machine zero gives zeros
// - floor passes nonnegative exponent unchanged
// - floor shifts with sign fill, flag 46
package sriu_pkg;
	localparam logic [7:0] OP_REG_BR   = 8'h33;
	localparam logic [7:0] OP_SHIFT    = 8'h34;
	localparam logic [7:0] OP_DEC_BR   = 8'h35;
	localparam logic [7:0] OP_BR_SET   = 8'h36;
	localparam logic [7:0] OP_TMR_RD   = 8'h37;
	localparam logic [7:0] OP_LEN_XFR  = 8'h38;
	localparam logic [7:0] OP_RTC_RD   = 8'h39;
	localparam logic [7:0] OP_TMR_WR   = 8'h3A;
	localparam logic [7:0] OP_FLAG_SWP = 8'h3B;
	localparam logic [7:0] OP_HMUL     = 8'h3C;
	localparam logic [7:0] OP_MUL      = 8'h3D;
	localparam logic [7:0] OP_ENTER    = 8'h3E;
	localparam logic [7:0] OP_INCR     = 8'h3F;
	localparam logic [7:0] OP_HENTER   = 8'h4D;
	localparam logic [7:0] OP_HINCR    = 8'h4E;
	localparam logic [7:0] OP_DIV_S    = 8'h4F;
	localparam logic [7:0] OP_TRUNC    = 8'h50;
	localparam logic [7:0] OP_FLOOR    = 8'h51;
	// fp op codes 40..4C; illegal holes
	localparam logic [7:0] OP_ILL_43   = 8'h43;
	localparam logic [7:0] OP_ILL_47   = 8'h47;
	localparam logic [7:0] OP_ILL_4A   = 8'h4A;
	localparam int FL_OVF  = 41;
	localparam int FL_UNF  = 42;
	localparam int FL_ZERO = 43;
	localparam int FL_IND  = 46;
	localparam int PROD_W  = 16;
	localparam int SHL_PA  = 5;
	localparam logic [63:0] FLAG_RST = 64'h0;
	typedef enum logic [1:0] {SRIU_IDLE = 2'b00, SRIU_WAIT = 2'b01, SRIU_DONE = 2'b11} sriu_st_t;
endpackage

// file: hdl/sriu_unit.sv
// scalar register instruction unit: one-cycle datapath with a flag-swap wait
`timescale 1ns/1ns
`default_nettype none
module sriu_unit
(
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        issue,
	input  wire logic [7:0]  opcode,
	input  wire logic [7:0]  g_des,
	input  wire logic [7:0]  r_des,
	input  wire logic [7:0]  s_des,
	input  wire logic [7:0]  t_des,
	input  wire logic [15:0] imm,
	input  wire logic [63:0] r_val,
	input  wire logic [63:0] s_val,
	input  wire logic [63:0] t_val,
	input  wire logic [47:0] prog_addr,
	input  wire logic [47:0] next_addr,
	input  wire logic [31:0] timer_val,
	input  wire logic [47:0] rtc_val,
	input  wire logic        monitor_mode,
	input  wire logic        flags_pending,
	input  wire logic [63:0] flag_set,
	input  wire logic [63:0] flag_mask,
	input  wire logic [63:0] fp_upper,
	input  wire logic [63:0] fp_lower,
	input  wire logic [63:0] fp_norm,
	input  wire logic [63:0] fp_sig,
	input  wire logic [3:0]  fp_flags,
	output var  logic        done,
	output var  logic        wr_en,
	output var  logic [7:0]  wr_addr,
	output var  logic [63:0] wr_data,
	output var  logic        wr2_en,
	output var  logic [63:0] wr2_data,
	output var  logic        br_take,
	output var  logic [47:0] br_addr,
	output var  logic        timer_wr,
	output var  logic [31:0] timer_data,
	output var  logic        illegal,
	output var  logic        flag_branch,
	output var  logic [63:0] flag_reg
);
	sriu_pkg::sriu_st_t st_q;
	logic [63:0] flags_q;
	logic [63:0] flags_d;

	////////////////////////////////////////////////////////////////////////
	// decode
	wire logic is_fp = (opcode >= 8'h40 && opcode <= 8'h4C && opcode != sriu_pkg::OP_HENTER)
		|| opcode == sriu_pkg::OP_DIV_S;
	wire logic is_ill = opcode == sriu_pkg::OP_ILL_43 || opcode == sriu_pkg::OP_ILL_47
		|| opcode == sriu_pkg::OP_ILL_4A;
	wire logic go = issue && st_q == sriu_pkg::SRIU_IDLE;

	////////////////////////////////////////////////////////////////////////
	// flag register: bits 0-15 are always the product of flag and mask
	// the raw low bits are never shown; both views rebuild the product field
	wire logic [63:0] flag_prod;
	wire logic [63:0] flag_prod_d;
	genvar gi;
	generate
		for (gi = 0; gi < sriu_pkg::PROD_W; gi++)
		begin : g_prod
			assign flag_prod[gi] = |(flags_q[63:16] & flag_mask[63:16]) & flag_mask[gi];
			assign flag_prod_d[gi] = |(flags_d[63:16] & flag_mask[63:16]) & flag_mask[gi];
		end
	endgenerate
	assign flag_prod[63:16] = flags_q[63:16];
	assign flag_prod_d[63:16] = flags_d[63:16];

	// object bit sampled from current flags; late arrivals only stored
	wire logic [5:0] obj_idx = imm[5:0];
	wire logic obj_bit = flag_prod[obj_idx];
	wire logic g0 = g_des[7];
	wire logic g1 = g_des[6];
	wire logic g2 = g_des[5];
	wire logic g3 = g_des[4];
	wire logic g5 = g_des[2];
	wire logic g6 = g_des[1];
	wire logic fb_take = (!g0 && g1) || (g0 && !g1 && obj_bit) || (g0 && g1 && !obj_bit);
	wire logic [47:0] ofs_pa = 48'({t_des, 5'h00});
	wire logic [47:0] fb_tgt = !g5 ? t_val[47:0]
		: (g6 ? prog_addr - ofs_pa : prog_addr + ofs_pa);
	logic alt_bit;
	always_comb
	begin
		unique case ({g2, g3})
			2'b00: alt_bit = obj_bit;
			2'b01: alt_bit = !obj_bit;
			2'b10: alt_bit = 1'b1;
			2'b11: alt_bit = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// shift: only low byte of S matters; R=0 reads machine zero
	wire logic [63:0] sh_src = (r_des == 8'h00) ? 64'h0 : r_val;
	wire logic [7:0]  sh_b = s_val[7:0];
	wire logic [5:0]  sh_n = sh_b[7] ? 6'(-sh_b) : sh_b[5:0];
	wire logic [127:0] rot2 = {sh_src, sh_src} << sh_n;
	wire logic [63:0] sh_res = sh_b[7] ? 64'($signed(sh_src) >>> sh_n)
		: rot2[127:64];

	// index arithmetic
	wire logic [47:0] dec_v = r_val[47:0] - 48'h1;
	wire logic [47:0] hw_tgt = t_val[47:0] + {s_val[42:0], 5'h00};
	wire logic signed [47:0] hprod = 48'($signed(r_val[23:0]) * $signed(s_val[23:0]));
	wire logic signed [95:0] fprod = $signed(r_val[47:0]) * $signed(s_val[47:0]);
	wire logic [47:0] imm48 = {{32{imm[15]}}, imm};
	wire logic [23:0] imm24 = {{8{imm[15]}}, imm};

	////////////////////////////////////////////////////////////////////////
	// truncate and floor on sign-magnitude-less 8-bit exp / 24-bit coef
	wire logic signed [7:0]  fexp = r_val[31:24];
	wire logic signed [23:0] fcoef = r_val[23:0];
	wire logic [7:0]  nsh = 8'(-fexp);
	wire logic [4:0]  nsh5 = (nsh > 8'h17) ? 5'h18 : nsh[4:0];
	wire logic [23:0] mag = fcoef[23] ? 24'(-fcoef) : fcoef;
	wire logic [23:0] tr_mag = mag >> nsh5;
	wire logic [23:0] tr_c = fcoef[23] ? 24'(-tr_mag) : tr_mag;
	wire logic [23:0] fl_c = 24'(fcoef >>> nsh5);
	wire logic mzero = fcoef == 24'h0;
	wire logic [31:0] tr_res = mzero ? 32'h0 : (!fexp[7] ? r_val[31:0] : {8'h00, tr_c});
	wire logic [31:0] fl_res = mzero ? 32'h0 : (!fexp[7] ? r_val[31:0] : {8'h00, fl_c});
	wire logic ind_in = fexp == 8'h80;

	////////////////////////////////////////////////////////////////////////
	// result select
	logic [63:0] res;
	logic        res_en;
	logic        take;
	logic [47:0] tgt;
	always_comb
	begin
		res = 64'h0;
		res_en = 1'b1;
		take = 1'b0;
		tgt = hw_tgt;
		unique case (opcode)
			sriu_pkg::OP_REG_BR:   begin res_en = 1'b0; take = fb_take; tgt = fb_tgt; end
			sriu_pkg::OP_SHIFT:    res = sh_res;
			sriu_pkg::OP_DEC_BR:   begin res = {r_val[63:48], dec_v}; take = dec_v != 48'h0; end
			sriu_pkg::OP_BR_SET:   begin res = {16'h0, next_addr}; take = 1'b1; end
			sriu_pkg::OP_TMR_RD:   res = {32'h0, timer_val};
			sriu_pkg::OP_LEN_XFR:  res = {r_val[63:48], t_val[47:0]};
			sriu_pkg::OP_RTC_RD:   res = {16'h0, rtc_val};
			sriu_pkg::OP_TMR_WR:   res_en = 1'b0;
			sriu_pkg::OP_HMUL:     res = {40'h0, hprod[23:0]};
			sriu_pkg::OP_MUL:      res = {16'h0, fprod[47:0]};
			sriu_pkg::OP_ENTER:    res = {16'h0, imm48};
			sriu_pkg::OP_INCR:     res = {r_val[63:48], 48'(r_val[47:0] + imm48)};
			sriu_pkg::OP_HENTER:   res = {40'h0, imm24};
			sriu_pkg::OP_HINCR:    res = {r_val[63:24], 24'(r_val[23:0] + imm24)};
			sriu_pkg::OP_TRUNC:    res = {32'h0, tr_res};
			sriu_pkg::OP_FLOOR:    res = {32'h0, fl_res};
			default:
			begin
				res_en = is_fp;
				unique case (opcode[1:0])
					2'b00: res = fp_upper;
					2'b01: res = fp_lower;
					2'b10: res = fp_norm;
					2'b11: res = fp_sig;
				endcase
				if (opcode == sriu_pkg::OP_DIV_S)
					res = fp_sig;
			end
		endcase
	end

	// data flag next value: hardware set kept except bits 41-46 during a float op; alter of bits 0-15 is lost
	always_comb
	begin
		flags_d = flags_q | flag_set;
		if (go && opcode == sriu_pkg::OP_REG_BR && obj_idx >= 6'h10)
			flags_d[obj_idx] = alt_bit | flag_set[obj_idx];
		if (go && is_fp && !is_ill)
			flags_d[sriu_pkg::FL_IND:sriu_pkg::FL_OVF] = flags_q[46:41]
				| {fp_flags[3], 2'b00, fp_flags[2:0]};
		if (go && (opcode == sriu_pkg::OP_TRUNC || opcode == sriu_pkg::OP_FLOOR) && ind_in)
			flags_d[sriu_pkg::FL_IND] = 1'b1;
		if (st_q == sriu_pkg::SRIU_WAIT && !flags_pending)
			flags_d = r_val | flag_set;
	end

	////////////////////////////////////////////////////////////////////////
	wire logic swap_go = go && opcode == sriu_pkg::OP_FLAG_SWP && !is_ill;
	wire logic swap_end = st_q == sriu_pkg::SRIU_WAIT && !flags_pending;
	wire logic new_hit = |(r_val[63:16] & flag_mask[63:16]);

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			st_q <= sriu_pkg::SRIU_IDLE;
			flags_q <= sriu_pkg::FLAG_RST;
			done <= 1'b0;
			wr_en <= 1'b0;
			wr_addr <= 8'h00;
			wr_data <= 64'h0;
			wr2_en <= 1'b0;
			wr2_data <= 64'h0;
			br_take <= 1'b0;
			br_addr <= 48'h0;
			timer_wr <= 1'b0;
			timer_data <= 32'h0;
			illegal <= 1'b0;
			flag_branch <= 1'b0;
			flag_reg <= sriu_pkg::FLAG_RST;
		end
		else
		begin
			flags_q <= flags_d;
			flag_reg <= flag_prod_d;
			done <= (go && !swap_go) || swap_end;
			wr_en <= go && !is_ill && res_en && !swap_go;
			wr2_en <= 1'b0;
			br_take <= go && !is_ill && take;
			timer_wr <= go && opcode == sriu_pkg::OP_TMR_WR && !monitor_mode;
			timer_data <= r_val[31:0];
			illegal <= go && is_ill;
			flag_branch <= swap_end && new_hit;
			if (go)
			begin
				wr_addr <= (opcode == sriu_pkg::OP_DEC_BR || opcode == sriu_pkg::OP_BR_SET
					|| opcode == sriu_pkg::OP_ENTER || opcode == sriu_pkg::OP_INCR
					|| opcode == sriu_pkg::OP_HENTER || opcode == sriu_pkg::OP_HINCR)
					? r_des : t_des;
				wr_data <= res;
				br_addr <= tgt;
			end
			if (swap_go)
				st_q <= sriu_pkg::SRIU_WAIT;
			else if (swap_end)
			begin
				// old flags go to T; R and T may be the same register
				st_q <= sriu_pkg::SRIU_IDLE;
				wr2_en <= 1'b1;
				wr2_data <= flag_prod;
				wr_addr <= t_des;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// every check looks one cycle after its trigger cycle
	property p_dec;
		@(posedge clk) disable iff (sys_rst)
		go && opcode == sriu_pkg::OP_DEC_BR |=> br_take == ($past(dec_v) != 48'h0);
	endproperty
	dec_branch_a: assert property (p_dec) else $error("decrement branch wrong");
	fb_add_a: assert property (@(posedge clk) disable iff (sys_rst)
		go && opcode == sriu_pkg::OP_REG_BR && fb_take && g5 && !g6
		|=> br_take && br_addr == 48'($past(prog_addr) + {$past(t_des), 5'h00}))
		else $error("flag branch target wrong");
	shift_rot_a: assert property (@(posedge clk) disable iff (sys_rst)
		go && opcode == sriu_pkg::OP_SHIFT && s_val[7:0] == 8'h01 && r_des != 8'h00
		|=> wr_data == {$past(r_val[62:0]), $past(r_val[63])})
		else $error("rotate wrong");
	shift_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
		go && opcode == sriu_pkg::OP_SHIFT && r_des == 8'h00
		|=> wr_data == 64'h0)
		else $error("shift of register zero wrong");
	br_set_a: assert property (@(posedge clk) disable iff (sys_rst)
		go && opcode == sriu_pkg::OP_BR_SET
		|=> br_take && wr_data == {16'h0, $past(next_addr)}
		&& br_addr == 48'($past(t_val[47:0]) + {$past(s_val[42:0]), 5'h00}))
		else $error("branch and set wrong");
	tmr_rd_a: assert property (@(posedge clk) disable iff (sys_rst)
		go && opcode == sriu_pkg::OP_TMR_RD
		|=> wr_data[63:32] == 32'h0 && wr_en)
		else $error("timer read wrong");
	len_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
		go && opcode == sriu_pkg::OP_LEN_XFR
		|=> wr_data == {$past(r_val[63:48]), $past(t_val[47:0])})
		else $error("length transfer wrong");
	rtc_rd_a: assert property (@(posedge clk) disable iff (sys_rst)
		go && opcode == sriu_pkg::OP_RTC_RD
		|=> wr_data == {16'h0, $past(rtc_val)})
		else $error("clock read wrong");
	tmr_mon_a: assert property (@(posedge clk) disable iff (sys_rst)
		go && monitor_mode |=> !timer_wr) else $error("timer load in monitor");
	tmr_job_a: assert property (@(posedge clk) disable iff (sys_rst)
		go && opcode == sriu_pkg::OP_TMR_WR && !monitor_mode
		|=> timer_wr && timer_data == $past(r_val[31:0]))
		else $error("timer load lost");
	swap_wait_a: assert property (@(posedge clk) disable iff (sys_rst)
		st_q == sriu_pkg::SRIU_WAIT && flags_pending |=> !wr2_en) else $error("swap early");
	swap_end_a: assert property (@(posedge clk) disable iff (sys_rst)
		swap_end
		|=> wr2_en && done && flag_reg[63:16] == $past(r_val[63:16] | flag_set[63:16]))
		else $error("swap did not finish");
	flag_br_a: assert property (@(posedge clk) disable iff (sys_rst)
		swap_end && new_hit
		|=> flag_branch)
		else $error("flag branch missed");
	hmul_clr_a: assert property (@(posedge clk) disable iff (sys_rst)
		go && opcode == sriu_pkg::OP_HMUL
		|=> wr_data[63:24] == 40'h0)
		else $error("half multiply upper bits");
	mul_clr_a: assert property (@(posedge clk) disable iff (sys_rst)
		go && opcode == sriu_pkg::OP_MUL
		|=> wr_data[63:48] == 16'h0)
		else $error("multiply upper bits");
	enter_ext_a: assert property (@(posedge clk) disable iff (sys_rst)
		go && opcode == sriu_pkg::OP_ENTER
		|=> wr_data[63:16] == {16'h0, {32{$past(imm[15])}}})
		else $error("enter sign wrong");
	incr_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
		go && opcode == sriu_pkg::OP_INCR
		|=> wr_data[63:48] == $past(r_val[63:48]))
		else $error("increase touched upper bits");
	henter_a: assert property (@(posedge clk) disable iff (sys_rst)
		go && opcode == sriu_pkg::OP_HENTER
		|=> wr_data[63:16] == {40'h0, {8{$past(imm[15])}}})
		else $error("half enter sign wrong");
	fp_sig_a: assert property (@(posedge clk) disable iff (sys_rst)
		go && opcode == sriu_pkg::OP_DIV_S
		|=> wr_en && wr_data == $past(fp_sig))
		else $error("divide result select wrong");
	trunc_pass_a: assert property (@(posedge clk) disable iff (sys_rst)
		go && opcode == sriu_pkg::OP_TRUNC && !fexp[7] && !mzero
		|=> wr_data[31:0] == $past(r_val[31:0]))
		else $error("truncate pass wrong");
	floor_pass_a: assert property (@(posedge clk) disable iff (sys_rst)
		go && opcode == sriu_pkg::OP_FLOOR && !fexp[7] && !mzero
		|=> wr_data[31:0] == $past(r_val[31:0]))
		else $error("floor pass wrong");
	floor_ind_a: assert property (@(posedge clk) disable iff (sys_rst)
		go && opcode == sriu_pkg::OP_FLOOR && ind_in
		|=> flags_q[sriu_pkg::FL_IND])
		else $error("floor indefinite flag");
	ill_exec_a: assert property (@(posedge clk) disable iff (sys_rst)
		go && is_ill |=> illegal && !wr_en && !br_take) else $error("illegal executed");
	flag_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
		st_q == sriu_pkg::SRIU_IDLE && flag_set[50] |=> flags_q[50]) else $error("flag lost");
	cv_swap: cover property (@(posedge clk) swap_go ##[1:20] flag_branch);
	cv_fbr: cover property (@(posedge clk) go && opcode == sriu_pkg::OP_REG_BR ##1 br_take);
	cv_ill: cover property (@(posedge clk) illegal);
	cv_shr: cover property (@(posedge clk) go && opcode == sriu_pkg::OP_SHIFT && s_val[7]);
	cv_dec_fall: cover property (@(posedge clk) go && opcode == sriu_pkg::OP_DEC_BR ##1 !br_take);
endmodule
`default_nettype wire

// file: tb/sriu_bench.sv
// self-checking bench for the scalar register instruction unit
`timescale 1ns/1ns
`default_nettype none
module scalar_register_instruction_unit_bench;
	logic              clk, sys_rst, issue, monitor_mode, flags_pending, done, wr_en, wr2_en;
	logic              br_take, timer_wr, illegal, flag_branch;
	logic [7:0]        opcode, g_des, r_des, s_des, t_des, wr_addr, fo [0:10], gt [0:3];
	logic [15:0]       imm;
	logic [63:0]       r_val, s_val, t_val, flag_set, flag_mask, wr_data, wr2_data, flag_reg;
	logic [63:0]       fp_upper, fp_lower, fp_norm, fp_sig, e, a;
	logic [47:0]       prog_addr, next_addr, rtc_val, br_addr;
	logic [31:0]       timer_val, timer_data;
	logic [3:0]        fp_flags;
	logic [23:0]       c, m;
	logic signed [47:0] x, y;
	int                n_mismatch, comparisons, cyc, n, fs [0:10];
	sriu_unit u_dut (.clk, .sys_rst, .issue, .opcode, .g_des, .r_des, .s_des, .t_des, .imm,
		.r_val, .s_val, .t_val, .prog_addr, .next_addr, .timer_val, .rtc_val, .monitor_mode,
		.flags_pending, .flag_set, .flag_mask, .fp_upper, .fp_lower, .fp_norm, .fp_sig,
		.fp_flags, .done, .wr_en, .wr_addr, .wr_data, .wr2_en, .wr2_data, .br_take, .br_addr,
		.timer_wr, .timer_data, .illegal, .flag_branch, .flag_reg);
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// ceiling well above the few hundred cycles the tests need
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 6000)
		begin
			n_mismatch++;
			final_report();
		end
	end
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic [63:0] ex, input logic [63:0] got);
		comparisons++;
		if (got !== ex)
		begin
			n_mismatch++;
			$display("Error t=%0t exp=%h got=%h", $time, ex, got);
		end
	endtask
	task automatic rnd();
		{r_val, s_val, t_val} = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
		{fp_upper, fp_lower} = {$urandom, $urandom, $urandom, $urandom};
		{fp_norm, fp_sig} = {$urandom, $urandom, $urandom, $urandom};
		{g_des, r_des, s_des, t_des} = $urandom;
		{prog_addr, next_addr} = {$urandom, $urandom, $urandom};
		{rtc_val, imm} = {$urandom, $urandom};
		timer_val = $urandom;
		fp_flags = 4'($urandom);
	endtask
	// a idle cycle before each issue keeps issue from being driven twice in one step
	task automatic run(input logic [7:0] op);
		int k;
		@(posedge clk);
		#1;
		opcode = op;
		issue = 1'b1;
		@(posedge clk);
		#1;
		issue = 1'b0;
		k = 0;
		while (!(done === 1'b1 || illegal === 1'b1) && k < 20)
		begin
			@(posedge clk);
			#1;
			k++;
		end
		chk(64'h1, {63'h0, done | illegal});
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		n = $urandom(32'h7FEE46B7);
		fo = '{8'h40, 8'h41, 8'h42, 8'h44, 8'h45, 8'h46, 8'h48, 8'h49, 8'h4B, 8'h4C, 8'h4F};
		fs = '{0, 1, 2, 0, 1, 2, 0, 1, 3, 0, 3};
		gt = '{8'h00, 8'h40, 8'h44, 8'h46};
		{issue, monitor_mode, flags_pending, opcode, flag_set, flag_mask} = '0;
		sys_rst = 1'b1;
		rnd();
		repeat (2) @(posedge clk);
		#1;
		sys_rst = 1'b0;
		for (int i = 0; i < 16; i++)
		begin
			rnd();
			n = $urandom_range(63, i % 2);
			s_val[7:0] = (i % 2) ? 8'(256 - n) : 8'(n);
			if (i == 2)
				r_des = 8'h00;
			a = (r_des == 8'h00) ? 64'h0 : r_val;
			if (i % 2)
				e = $signed(a) >>> n;
			else
				e = (a << n) | (a >> (64 - n));
			run(sriu_pkg::OP_SHIFT);
			chk(e, wr_data);
			chk(t_des, wr_addr);
		end
		$display("test shift done");
		for (int i = 0; i < 4; i++)
		begin
			rnd();
			if (i == 0)
				r_val[47:0] = 48'h1;
			run(sriu_pkg::OP_DEC_BR);
			chk({r_val[63:48], r_val[47:0] - 48'h1}, wr_data);
			chk(i != 0, br_take);
			if (i != 0)
				chk(48'(t_val[47:0] + {s_val[42:0], 5'h0}), br_addr);
		end
		rnd();
		run(sriu_pkg::OP_BR_SET);
		chk({16'h0, next_addr}, wr_data);
		chk(48'(t_val[47:0] + {s_val[42:0], 5'h0}), br_addr);
		for (int i = 0; i < 4; i++)
		begin
			rnd();
			g_des = gt[i];
			run(sriu_pkg::OP_REG_BR);
			e = i == 1 ? t_val : i == 2 ? prog_addr + {t_des, 5'h0} : prog_addr - {t_des, 5'h0};
			chk(i != 0, br_take);
			if (i != 0)
				chk(e[47:0], br_addr);
		end
		$display("test branch done");
		rnd();
		run(sriu_pkg::OP_TMR_RD);
		chk({32'h0, timer_val}, wr_data);
		run(sriu_pkg::OP_LEN_XFR);
		chk({r_val[63:48], t_val[47:0]}, wr_data);
		run(sriu_pkg::OP_RTC_RD);
		chk({16'h0, rtc_val}, wr_data);
		for (int i = 0; i < 2; i++)
		begin
			monitor_mode = i[0];
			run(sriu_pkg::OP_TMR_WR);
			chk(i == 0, timer_wr);
			if (i == 0)
				chk(r_val[31:0], timer_data);
		end
		monitor_mode = 1'b0;
		$display("test transfer done");
		// operands kept small: products beyond the signed range are undefined
		for (int i = 0; i < 8; i++)
		begin
			rnd();
			x = $signed(20'($urandom));
			y = $signed(20'($urandom));
			{r_val[47:0], s_val[47:0]} = {x, y};
			run(sriu_pkg::OP_MUL);
			chk({16'h0, 48'(x * y)}, wr_data);
			x = $signed(11'($urandom));
			y = $signed(11'($urandom));
			{r_val[23:0], s_val[23:0]} = {x[23:0], y[23:0]};
			run(sriu_pkg::OP_HMUL);
			chk({8'h0, 24'(x[23:0] * y[23:0])}, wr_data[31:0]);
			run(sriu_pkg::OP_ENTER);
			chk({16'h0, {32{imm[15]}}, imm}, wr_data);
			chk(r_des, wr_addr);
			run(sriu_pkg::OP_INCR);
			chk({r_val[63:48], r_val[47:0] + {{32{imm[15]}}, imm}}, wr_data);
			run(sriu_pkg::OP_HENTER);
			chk({8'h0, {8{imm[15]}}, imm}, wr_data[31:0]);
			run(sriu_pkg::OP_HINCR);
			chk({r_val[31:24], r_val[23:0] + {{8{imm[15]}}, imm}}, wr_data[31:0]);
		end
		$display("test index done");
		for (int i = 0; i < 11; i++)
		begin
			rnd();
			e = fs[i] == 0 ? fp_upper : fs[i] == 1 ? fp_lower : fs[i] == 2 ? fp_norm : fp_sig;
			run(fo[i]);
			chk(e, wr_data);
		end
		for (int i = 0; i < 3; i++)
		begin
			run(i == 0 ? sriu_pkg::OP_ILL_43 : i == 1 ? sriu_pkg::OP_ILL_47 : sriu_pkg::OP_ILL_4A);
			chk(64'h1, illegal);
			chk(64'h0, wr_en);
		end
		for (int i = 0; i < 8; i++)
		begin
			rnd();
			n = (i == 0) ? 0 : $urandom_range(23, 1);
			c = 24'($urandom);
			r_val[31:0] = {8'(-n), c};
			m = (c[23] ? -c : c) >> n;
			run(sriu_pkg::OP_TRUNC);
			chk(i ? {8'h0, c[23] ? -m : m} : r_val[31:0], wr_data[31:0]);
			run(sriu_pkg::OP_FLOOR);
			chk(i ? {8'h0, 24'($signed(c) >>> n)} : r_val[31:0], wr_data[31:0]);
		end
		$display("test float done");
		for (int i = 0; i < 2; i++)
		begin
			rnd();
			flags_pending = 1'b1;
			flag_mask = i ? 64'h0001_0000_0000_0000 : 64'h0;
			r_val[48] = 1'b1;
			fork
				run(sriu_pkg::OP_FLAG_SWP);
				begin
					repeat (3)
					begin
						@(posedge clk);
						#1;
						chk(64'h0, done);
					end
					flags_pending = 1'b0;
				end
			join
			chk(64'h1, wr2_en);
			chk(r_val[63:16], flag_reg[63:16]);
			chk(64'h0, flag_reg[15:0]);
			chk(i, flag_branch);
			if (i == 1)
				chk(e[63:16], wr2_data[63:16]);
			e = r_val;
			e[40] = 1'b1;
			flag_set[40] = 1'b1;
			@(posedge clk);
			#1;
			flag_set = '0;
			@(posedge clk);
			#1;
			chk(64'h1, flag_reg[40]);
		end
		$display("test flag swap done");
		final_report();
	end
endmodule
`default_nettype wire
